/* File: verilog/rsp_rx_out.sv */
// Overview of operation
// - Received data leaves on four segments, each carrying 128 data bits.
// - Segment data is meaningful only while that segment's enable is high.
// - Enable qualifies start, end, data and status of its own segment.
// - Start marker rises with enable on the segment holding a packet's first bytes.
// - End marker rises with enable on the segment holding a packet's last bytes.
// - Error flag marks the ending packet bad; meaningful only with enable and end.
// - Four-bit empty count gives unused byte lanes of the final transfer.
// - With error and enable high, low three empty bits are forced zero.
`timescale 1ns/1ps

module rsp_rx_out
    import rsp_pkg::*;
(
    // Clock and reset
    input  wire logic     clock_i,
    input  wire logic     rst_b_i,
    // Segments from the receive engine, same clock
    input  wire rsp_seg_t seg_i [NUM_SEG],
    // Segmented local packet bus to user logic
    output rsp_seg_t      seg_o [NUM_SEG],
    // Packet currently open across cycles
    output logic          in_packet_o
);

    // ****************************************************************
    // Segment cleanup
    // ****************************************************************

    // Builds the outgoing view of one segment; idle fields are forced to
    // zero so that user logic never sees stale values on a quiet lane.
    function automatic rsp_seg_t clean_seg(input rsp_seg_t s, input logic stray_end);
        rsp_seg_t r;
        r = SEG_IDLE;
        if (s.enable) begin
            r.enable              = 1'b1;
            r.data                = s.data;
            r.packet_start_marker = s.packet_start_marker;
            r.packet_end_marker   = s.packet_end_marker;
            if (s.packet_end_marker) begin
                // An end without an open packet is reported as a bad packet
                r.error = s.error | stray_end;
                r.empty = s.empty;
                if (r.error) begin
                    r.empty[EMPTY_ERR_W-1:0] = EMPTY_ERR_LO;
                end
            end
        end
        return r;
    endfunction

    // Enabled start and enabled end of one segment; a marker on a quiet
    // segment means nothing and must never move the framing state.
    function automatic logic seg_opens(input rsp_seg_t s);
        return s.enable && s.packet_start_marker;
    endfunction

    function automatic logic seg_closes(input rsp_seg_t s);
        return s.enable && s.packet_end_marker;
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    rsp_seg_t seg_d [NUM_SEG];
    rsp_seg_t seg_q [NUM_SEG];
    logic     open_d;
    logic     open_q;
    logic     mark_seen; // Any enabled marker this cycle, read by the checks

    // Walk the segments in byte order, tracking packet framing
    always_comb begin
        logic open_v;
        logic stray_v;
        open_v    = open_q;
        stray_v   = 1'b0;
        mark_seen = 1'b0;
        for (int i = 0; i < NUM_SEG; i++) begin
            stray_v = 1'b0;
            // Start is taken before end, so a one-segment packet is not stray
            if (seg_opens(seg_i[i])) begin
                open_v = 1'b1;
            end
            if (seg_closes(seg_i[i])) begin
                stray_v = !open_v;
                open_v  = 1'b0;
            end
            mark_seen = mark_seen | seg_opens(seg_i[i]) | seg_closes(seg_i[i]);
            seg_d[i]  = clean_seg(seg_i[i], stray_v);
        end
        open_d = open_v;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************

    // Limitation: a start while a packet is open simply reopens it; the
    // cut packet is not flagged and user logic sees only a missing end.
    // Output stage; outputs leave straight from these flops for timing
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NUM_SEG; i++) begin
                seg_q[i] <= SEG_IDLE;
            end
            open_q <= OPEN_RST;
        end else begin
            for (int i = 0; i < NUM_SEG; i++) begin
                seg_q[i] <= seg_d[i];
            end
            open_q <= open_d;
        end
    end

    // Port drive
    always_comb begin
        for (int i = 0; i < NUM_SEG; i++) begin
            seg_o[i] = seg_q[i];
        end
        in_packet_o = open_q;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // A beat taken at one edge shows at the next, hence the $past terms;
    // the reset guard keeps the first edge after release out of them.
    for (genvar g = 0; g < NUM_SEG; g++) begin : g_chk

        ena_follow_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            $past(rst_b_i) |-> seg_o[g].enable == $past(seg_i[g].enable))
            else $error("segment enable does not follow its source");

        data_pass_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            $past(rst_b_i) && $past(seg_i[g].enable)
            |-> seg_o[g].data == $past(seg_i[g].data))
            else $error("enabled segment data not passed through");

        idle_clean_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            !seg_o[g].enable |-> seg_o[g].data == DATA_IDLE
                && !seg_o[g].packet_start_marker && !seg_o[g].packet_end_marker
                && !seg_o[g].error && seg_o[g].empty == EMPTY_IDLE)
            else $error("idle segment shows non-zero fields");

        start_pass_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            $past(rst_b_i) && $past(seg_i[g].enable)
            |-> seg_o[g].packet_start_marker == $past(seg_i[g].packet_start_marker))
            else $error("start marker lost or invented");

        end_pass_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            $past(rst_b_i) && $past(seg_i[g].enable)
            |-> seg_o[g].packet_end_marker == $past(seg_i[g].packet_end_marker))
            else $error("end marker lost or invented");

        err_at_end_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            seg_o[g].error |-> seg_o[g].enable && seg_o[g].packet_end_marker)
            else $error("error flag outside an enabled end");

        err_kept_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            $past(rst_b_i) && $past(seg_i[g].enable && seg_i[g].packet_end_marker
                && seg_i[g].error) |-> seg_o[g].error)
            else $error("source error not reported at end");

        empty_pass_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            $past(rst_b_i) && seg_o[g].enable && seg_o[g].packet_end_marker
                && !seg_o[g].error |-> seg_o[g].empty == $past(seg_i[g].empty))
            else $error("empty count altered on good end");

        empty_force_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            seg_o[g].enable && seg_o[g].error
            |-> seg_o[g].empty[EMPTY_ERR_W-1:0] == EMPTY_ERR_LO
                && seg_o[g].empty[EMPTY_W-1] == $past(seg_i[g].empty[EMPTY_W-1]))
            else $error("empty low bits not cleared on error");

        status_quiet_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            !(seg_o[g].enable && seg_o[g].packet_end_marker)
            |-> !seg_o[g].error && seg_o[g].empty == EMPTY_IDLE)
            else $error("status shown without an enabled end");

        reset_idle_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            !$past(rst_b_i) |-> seg_o[g] == SEG_IDLE)
            else $error("segment not idle after reset");

        single_seg_a: assert property (
            @(posedge clock_i) disable iff (!rst_b_i)
            $past(rst_b_i) && $past(seg_i[g].enable && seg_i[g].packet_start_marker
                && seg_i[g].packet_end_marker && !seg_i[g].error) |-> !seg_o[g].error)
            else $error("one-segment packet wrongly flagged as errored");
    end

    order_track_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        $past(rst_b_i) && seg_o[NUM_SEG-1].enable
            && seg_o[NUM_SEG-1].packet_start_marker
            && !seg_o[NUM_SEG-1].packet_end_marker |-> in_packet_o)
        else $error("packet opened on last segment not tracked");

    close_last_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        seg_o[NUM_SEG-1].enable && seg_o[NUM_SEG-1].packet_end_marker |-> !in_packet_o)
        else $error("packet ended on last segment still open");

    open_hold_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        $past(rst_b_i) && !$past(mark_seen) |-> in_packet_o == $past(in_packet_o))
        else $error("packet state moved without a marker");

    stray_err_a: assert property (
        @(posedge clock_i) disable iff (!rst_b_i)
        $past(rst_b_i) && seg_o[0].error && !$past(seg_i[0].error)
        |-> !$past(in_packet_o) && !$past(seg_i[0].packet_start_marker))
        else $error("error raised on segment zero inside an open packet");

endmodule // rsp_rx_out

/* File: verilog/rsp_pkg.sv */
// ****************************************************************
// Segmented receive output bus: shared constants and carriers
// ****************************************************************
package rsp_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int NUM_SEG     = 4;    // Parallel segments per cycle
    localparam int SEG_DATA_W  = 128;  // Data bits per segment
    localparam int SEG_BYTES   = SEG_DATA_W / 8;
    localparam int EMPTY_W     = 4;    // Empty byte-lane count width
    localparam int EMPTY_ERR_W = 3;    // Low empty bits cleared on error

    // ****************************************************************
    // Reset and idle values
    // ****************************************************************
    localparam logic [SEG_DATA_W-1:0]  DATA_IDLE    = '0;
    localparam logic [EMPTY_W-1:0]     EMPTY_IDLE   = 4'h0;
    localparam logic [EMPTY_ERR_W-1:0] EMPTY_ERR_LO = 3'h0;
    localparam logic                   OPEN_RST     = 1'b0;

    // ****************************************************************
    // One segment of the segmented local packet bus
    // ****************************************************************
    typedef struct packed {
        logic                  enable;              // Qualifies all other fields
        logic                  packet_start_marker; // First bytes of a packet
        logic                  packet_end_marker;   // Final bytes of a packet
        logic                  error;               // Packet ended with error
        logic [EMPTY_W-1:0]    empty;               // Unused lanes at end
        logic [SEG_DATA_W-1:0] data;                // First byte in top lane
    } rsp_seg_t;

    localparam rsp_seg_t SEG_IDLE = '{
        enable: 1'b0, packet_start_marker: 1'b0, packet_end_marker: 1'b0,
        error: 1'b0, empty: EMPTY_IDLE, data: DATA_IDLE
    };

endpackage

/* File: bench/rsp_user_sink.sv */
`timescale 1ns/1ps

module rsp_user_sink
    import rsp_pkg::*;
(
    // Clock
    input  wire logic     clock_i,
    // Segmented local packet bus from the device
    input  wire rsp_seg_t seg_i [NUM_SEG],
    // Packet ends seen
    output int            pkt_count_o
);
    // Count ends; a segment with enable low is ignored whatever it shows
    initial pkt_count_o = 0;
    always @(posedge clock_i) begin : count_ends
        int n;
        n = 0;
        for (int s = 0; s < NUM_SEG; s++) begin
            if (seg_i[s].enable === 1'b1 && seg_i[s].packet_end_marker === 1'b1) begin
                n++;
            end
        end
        pkt_count_o <= pkt_count_o + n;
    end
endmodule // rsp_user_sink

/* File: bench/tb.sv */
`timescale 1ns/1ps

module tb;
    import rsp_pkg::*;
    logic     clock_i;
    logic     rst_b_i;
    rsp_seg_t seg_i [NUM_SEG];
    rsp_seg_t seg_o [NUM_SEG];
    logic     in_packet_o;
    rsp_seg_t exp_q [NUM_SEG];
    logic     exp_open;
    logic     open_m;
    int       err_count, tests_run, cycles, pkts, ends_m;
    localparam int MAX_CYCLES = 2000; // About twice the planned run

    rsp_user_sink i_rsp_user_sink (.clock_i(clock_i), .seg_i(seg_o), .pkt_count_o(pkts));
    rsp_rx_out i_rsp_rx_out (.clock_i(clock_i), .rst_b_i(rst_b_i), .seg_i(seg_i),
                             .seg_o(seg_o), .in_packet_o(in_packet_o));

    // ****************************************************************
    // Clock and hang guard
    // ****************************************************************
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        cycles = 0;
        while (cycles < MAX_CYCLES) begin
            @(posedge clock_i);
            cycles++;
        end
        err_count++;
        $display("[FAIL] %0t cycle ceiling reached", $time);
        report_and_stop();
    end

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Compare last beat, then drive and model the next one at the falling edge
    task automatic step(input logic rst_b, input logic live);
        rsp_seg_t e;
        @(negedge clock_i);
        tests_run++;
        // Sink counts a beat at the edge after its compare, so it lags one step
        if (pkts !== ends_m) begin
            err_count++;
            $display("[FAIL] %0t sink counted %0d ends, model %0d", $time, pkts, ends_m);
        end
        for (int s = 0; s < NUM_SEG; s++) begin
            if (seg_o[s] !== exp_q[s]) begin
                err_count++;
                $display("[FAIL] %0t segment %0d differs from model", $time, s);
            end
            if (exp_q[s].enable && exp_q[s].packet_end_marker) begin
                ends_m++;
            end
        end
        if (in_packet_o !== exp_open) begin
            err_count++;
            $display("[FAIL] %0t open packet status differs", $time);
        end
        rst_b_i = rst_b;
        for (int s = 0; s < NUM_SEG; s++) begin
            seg_i[s] = SEG_IDLE;
            if (live) begin
                seg_i[s].enable = ($urandom % 4) != 0;
                seg_i[s].packet_start_marker = ($urandom % 3) == 0;
                seg_i[s].packet_end_marker = ($urandom % 3) == 0;
                seg_i[s].error = ($urandom % 4) == 0;
                seg_i[s].empty = 4'($urandom);
                seg_i[s].data = {$urandom, $urandom, $urandom, $urandom};
            end
            // Order of segments matters: packet state runs 0 to 3
            e = SEG_IDLE;
            if (seg_i[s].enable) begin
                e = seg_i[s];
                if (e.packet_start_marker) open_m = 1'b1;
                if (e.packet_end_marker) begin
                    if (!open_m) e.error = 1'b1;
                    open_m = 1'b0;
                end else begin
                    e.error = 1'b0;
                    e.empty = EMPTY_IDLE;
                end
                if (e.error) e.empty[2:0] = 3'h0;
            end
            if (!rst_b) e = SEG_IDLE;
            exp_q[s] = e;
        end
        if (!rst_b) open_m = 1'b0;
        exp_open = open_m;
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(32'hd031));
        err_count = 0;
        tests_run = 0;
        ends_m = 0;
        open_m = 1'b0;
        exp_open = 1'b0;
        rst_b_i = 1'b0;
        foreach (seg_i[s]) begin
            seg_i[s] = SEG_IDLE;
            exp_q[s] = SEG_IDLE;
        end
        repeat (16) step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        repeat (600) step(1'b1, 1'b1);
        $display("random traffic done");
        // Reset in mid-packet must close any open packet
        repeat (2) step(1'b0, 1'b1);
        step(1'b1, 1'b0);
        repeat (300) step(1'b1, 1'b1);
        // Idle beats let the last random beat and its end count be checked
        repeat (2) step(1'b1, 1'b0);
        $display("traffic after second reset done, %0d ends seen", pkts);
        report_and_stop();
    end
endmodule // tb
